//--- verilog/cmf_cfg.svh
`ifndef CMF_CFG_SVH
`define CMF_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CMF_OFF_CTRL 12'h000
`define CMF_OFF_STATUS 12'h004
`define CMF_OFF_FAULT 12'h008
`define CMF_OFF_SENSE 12'h00C

// ****************************************************************
// control register fields
// ****************************************************************
`define CMF_CTRL_KICK 0
`define CMF_CTRL_STATEN 1
`define CMF_CTRL_CHGDIS 2
`define CMF_CTRL_PRST 3
`define CMF_CTRL_OPSEL 4
`define CMF_CTRL_HIZ 5
`define CMF_CTRL_RESET 32'h0000_0000

// ****************************************************************
// fault register fields (write one to clear, except the charge bit, which follows the charge fault condition)
// ****************************************************************
`define CMF_FLT_TIMER 0
`define CMF_FLT_BUSOV 1
`define CMF_FLT_OVLD 2
`define CMF_FLT_BATT 3
`define CMF_FLT_CHG 4

// ****************************************************************
// timing
// ****************************************************************
`define CMF_CLK_HZ 50000000
`define CMF_PULSE_US 128
`define CMF_PULSE_CYC ((`CMF_PULSE_US * (`CMF_CLK_HZ / 1000000)))
`define CMF_OVLD_MS 30
`define CMF_OVLD_CYC (`CMF_OVLD_MS * (`CMF_CLK_HZ / 1000))
`define CMF_T32S_S 32
`define CMF_T32S_CYC (`CMF_T32S_S * `CMF_CLK_HZ)

`endif

//--- verilog/cmf_pkg.sv
package cmf_pkg;

  typedef enum logic [3:0] {
    CMF_HIZ = 4'h1,
    CMF_CFG = 4'h2,
    CMF_CHG = 4'h4,
    CMF_BST = 4'h8
  } cmf_mode_t;

  typedef struct packed {
    logic busAboveLockout;
    logic busOver;
    logic battOver;
    logic battUnder;
    logic battWeak;
    logic overload;
    logic thermal;
    logic sleep;
    logic poorSource;
    logic noBattery;
    logic chargeTimerFault;
    logic inductorLow;
    logic midRailLow;
  } cmf_sense_t;

  typedef struct packed {
    logic pwmOn;
    logic boostOn;
    logic chargeOn;
    logic paramReset;
  } cmf_power_t;

  typedef struct packed {
    cmf_mode_t mode;
    logic [5:0] ctrl;
    logic [4:0] fault;
    logic hostMode;
    logic [30:0] boostTmr;
    logic [30:0] crudeTmr;
    logic [20:0] ovldTmr;
    logic [12:0] pulseTmr;
    logic prevFault;
    logic skip;
    logic statDrive;
    cmf_power_t pwr;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } cmf_state_t;

endpackage

//--- verilog/cmf_charger_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmf_cfg.svh"

// Summary of operation
// - status pin pulled low while charging and status enable bit set
// - otherwise the status pin is released
// - a fault gives one 128 us low pulse, then release
// - charge faults: timer, sleep, overvoltage, poor source, lockout, no battery, heat
// - boost faults: timer, overload, overvoltage, low battery, heat
// - charge disable bit low enables charging, high disables it
// - parameter reset bit restores defaults then clears itself
// - select 0, no hiz: charge; fault to configure above lockout, else hiz
// - select 1, no hiz: boost, fault to configure; hiz request gives hiz
// - in host mode, boost when otg pin active or select bit set
// - boost skips pulses below 75 mA, resumes when mid rail sags
// - boost starts a 32 s timer; kick restarts it and self-clears
// - host kicks repeatedly; expiry stops boost, pulses, sets fault
// - boost timer fault held until reset or host clear
// - bus overvoltage stops boost, clears select, sets fault, pulses
// - overload longer than 30 ms is a fault with the same actions
// - after overload fault, no boost until fault register cleared
// - battery out of range in boost: stop, clear select, fault, pulse
// - normal boosting leaves the status pin released
// - hiz request with otg inactive enters high impedance
// - hiz with weak battery runs crude 32 s timer into no-host mode
// - no-host mode with bus below lockout forces high impedance
// - any host write enters host mode and restarts the 32 s timer
module cmf_charger_ctrl
  import cmf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // analog monitors and pins
  input wire cmf_sense_t sense,
  input wire logic otgActive,
  // status pin, open drain
  input wire logic statIn,
  output logic statOut,
  output logic statOe,
  // power stage controls
  output cmf_power_t power,
  output cmf_mode_t mode
);

  cmf_state_t st;
  cmf_state_t next_st;
  logic setup;
  logic wr;
  logic rd;
  logic boostFault;
  logic chargeFault;
  logic anyFault;
  logic [5:0] ctrlW;
  logic [4:0] fltSet;
  logic [4:0] fltClr;
  logic boostReq;
  logic boostBlock;
  logic unmapped;
  logic chargeCond;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // access completes in the first access cycle; pready is registered
  assign setup = psel && !penable;
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;
  assign unmapped = !(hit(paddr, `CMF_OFF_CTRL) ||
    hit(paddr, `CMF_OFF_STATUS) || hit(paddr, `CMF_OFF_FAULT) ||
    hit(paddr, `CMF_OFF_SENSE));

  always_comb
  begin
    next_st = st;
    ctrlW = st.ctrl;
    fltSet = 5'h00;
    fltClr = 5'h00;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.pwr.paramReset = 1'b0;

    // **************************************************************
    // register writes
    // **************************************************************
    if (wr && hit(paddr, `CMF_OFF_CTRL))
    begin
      ctrlW = pwdata[5:0];
    end
    if (wr && hit(paddr, `CMF_OFF_FAULT))
    begin
      fltClr = pwdata[4:0];
    end
    if (wr)
    begin
      next_st.hostMode = 1'b1;
      next_st.crudeTmr = 31'h0000_0000;
    end
    if (setup)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = unmapped;
      next_st.prdata = 32'h0000_0000;
      if (rd && hit(paddr, `CMF_OFF_CTRL))
      begin
        next_st.prdata = {26'h000_0000, st.ctrl};
      end
      if (rd && hit(paddr, `CMF_OFF_STATUS))
      begin
        next_st.prdata = {24'h00_0000, st.statDrive, st.skip,
          st.hostMode, st.mode, 1'b0};
      end
      if (rd && hit(paddr, `CMF_OFF_FAULT))
      begin
        next_st.prdata = {27'h000_0000, st.fault};
      end
      if (rd && hit(paddr, `CMF_OFF_SENSE))
      begin
        next_st.prdata = {18'h0_0000, otgActive, sense};
      end
    end

    // **************************************************************
    // self-clearing bits
    // **************************************************************
    if (ctrlW[`CMF_CTRL_PRST])
    begin
      next_st.pwr.paramReset = 1'b1;
      ctrlW = 6'h00;
    end

    // **************************************************************
    // boost protection
    // **************************************************************
    if (st.mode == CMF_BST && sense.overload)
    begin
      if (st.ovldTmr >= 21'(`CMF_OVLD_CYC))
      begin
        fltSet[`CMF_FLT_OVLD] = 1'b1;
      end
      else
      begin
        next_st.ovldTmr = st.ovldTmr + 21'h00_0001;
      end
    end
    else
    begin
      next_st.ovldTmr = 21'h00_0000;
    end

    if (st.mode == CMF_BST)
    begin
      if (ctrlW[`CMF_CTRL_KICK])
      begin
        next_st.boostTmr = 31'h0000_0000;
      end
      else if (st.boostTmr >= 31'(`CMF_T32S_CYC - 1))
      begin
        fltSet[`CMF_FLT_TIMER] = 1'b1;
      end
      else if (!sense.thermal)
      begin
        next_st.boostTmr = st.boostTmr + 31'h0000_0001;
      end
      fltSet[`CMF_FLT_BUSOV] = sense.busOver;
      fltSet[`CMF_FLT_BATT] = sense.battOver || sense.battUnder;
    end
    else
    begin
      next_st.boostTmr = 31'h0000_0000;
    end
    ctrlW[`CMF_CTRL_KICK] = 1'b0;

    chargeCond = sense.chargeTimerFault || sense.sleep ||
      sense.busOver || sense.battOver || sense.poorSource ||
      !sense.busAboveLockout || sense.noBattery || sense.thermal;
    // held through configure so the mode does not bounce back to charge
    if (st.mode == CMF_CHG || st.mode == CMF_CFG)
    begin
      fltSet[`CMF_FLT_CHG] = chargeCond;
    end

    if (|fltSet[3:1])
    begin
      ctrlW[`CMF_CTRL_OPSEL] = 1'b0;
    end
    // a new fault beats a simultaneous clear
    next_st.fault = (st.fault & ~fltClr) | fltSet;
    next_st.fault[`CMF_FLT_CHG] = fltSet[`CMF_FLT_CHG];
    next_st.ctrl = ctrlW;

    // **************************************************************
    // crude timer for host presence
    // **************************************************************
    if (st.mode == CMF_HIZ && sense.battWeak && st.hostMode && !wr)
    begin
      if (st.crudeTmr >= 31'(`CMF_T32S_CYC - 1))
      begin
        next_st.hostMode = 1'b0;
        next_st.crudeTmr = 31'h0000_0000;
      end
      else
      begin
        next_st.crudeTmr = st.crudeTmr + 31'h0000_0001;
      end
    end

    // **************************************************************
    // mode selection
    // **************************************************************
    boostFault = (|fltSet[3:0]) || sense.thermal;
    chargeFault = fltSet[`CMF_FLT_CHG] || st.ctrl[`CMF_CTRL_CHGDIS];
    // overload and timer faults must be cleared by the host first
    boostBlock = st.fault[`CMF_FLT_OVLD] || st.fault[`CMF_FLT_TIMER];
    boostReq = st.hostMode &&
      (otgActive || st.ctrl[`CMF_CTRL_OPSEL]);
    // charge disable is a normal condition and gives no fault pulse
    anyFault = boostReq ? boostFault : fltSet[`CMF_FLT_CHG];
    if (!st.hostMode && !sense.busAboveLockout)
    begin
      next_st.mode = CMF_HIZ;
    end
    else if (st.ctrl[`CMF_CTRL_HIZ] && !otgActive)
    begin
      next_st.mode = CMF_HIZ;
    end
    else if (boostReq)
    begin
      next_st.mode = (boostFault || boostBlock) ? CMF_CFG : CMF_BST;
    end
    else if (!sense.busAboveLockout)
    begin
      next_st.mode = CMF_HIZ;
    end
    else
    begin
      next_st.mode = chargeFault ? CMF_CFG : CMF_CHG;
    end

    // pulse skipping: stop below 75 mA, resume on mid rail sag
    if (st.mode != CMF_BST || sense.midRailLow)
    begin
      next_st.skip = 1'b0;
    end
    else if (sense.inductorLow)
    begin
      next_st.skip = 1'b1;
    end

    next_st.pwr.boostOn = (next_st.mode == CMF_BST);
    next_st.pwr.chargeOn = (next_st.mode == CMF_CHG);
    next_st.pwr.pwmOn = (next_st.mode == CMF_CHG) ||
      ((next_st.mode == CMF_BST) && !next_st.skip);

    // **************************************************************
    // status pin
    // **************************************************************
    next_st.prevFault = anyFault && (st.mode != CMF_HIZ);
    if (st.pulseTmr != 13'h0000)
    begin
      next_st.pulseTmr = st.pulseTmr - 13'h0001;
    end
    else if (next_st.prevFault && !st.prevFault)
    begin
      next_st.pulseTmr = 13'(`CMF_PULSE_CYC);
    end
    next_st.statDrive = (next_st.pulseTmr != 13'h0000) ||
      (next_st.prevFault && !st.prevFault) ||
      ((next_st.mode == CMF_CHG) &&
      st.ctrl[`CMF_CTRL_STATEN]);
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '{mode: CMF_HIZ, ctrl: 6'h00, fault: 5'h00, hostMode: 1'b0,
        boostTmr: 31'h0000_0000, crudeTmr: 31'h0000_0000,
        ovldTmr: 21'h00_0000, pulseTmr: 13'h0000, prevFault: 1'b0,
        skip: 1'b0, statDrive: 1'b0, pwr: 4'h0, pready: 1'b0,
        prdata: 32'h0000_0000, pslverr: 1'b0};
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign statOut = 1'b0;
  assign statOe = st.statDrive;
  assign power = st.pwr;
  assign mode = st.mode;

endmodule // cmf_charger_ctrl
`default_nettype wire

//--- testbench/cmf_charger_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmf_cfg.svh"
module cmf_charger_ctrl_assertions
  import cmf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bus
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and power stage
  input wire cmf_sense_t sense,
  input wire logic statOut,
  input wire logic statOe,
  input wire cmf_power_t power,
  input wire cmf_mode_t mode
);
  localparam int PulseCyc = `CMF_PULSE_CYC;
  logic [12:0] hiCnt;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // pin held low outside charge can only be the fault pulse
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      hiCnt <= '0;
    else if (statOe && mode != CMF_CHG)
      hiCnt <= hiCnt + 13'h1;
    else
      hiCnt <= '0;
  take_ready_a: assert property (psel && !penable && clkEn |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  drain_open_a: assert property (statOut == 1'b0)
    else $error("status pin driven high");
  pulse_len_a: assert property (hiCnt <= PulseCyc)
    else $error("fault pulse too long");
  boost_ovp_a: assert property (clkEn && mode == CMF_BST && sense.busOver |=> mode != CMF_BST)
    else $error("boost kept on bus overvoltage");
  boost_batt_a: assert property (clkEn && mode == CMF_BST && (sense.battOver || sense.battUnder) |=> mode != CMF_BST)
    else $error("boost kept on battery range");
  boost_heat_a: assert property (clkEn && mode == CMF_BST && sense.thermal |=> mode != CMF_BST)
    else $error("boost kept on thermal");
  boost_power_a: assert property (mode == CMF_BST |-> ##[0:1] power.boostOn)
    else $error("boost mode without converter");
endmodule // cmf_charger_ctrl_assertions
bind cmf_charger_ctrl cmf_charger_ctrl_assertions chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .sense(sense),
  .statOut(statOut), .statOe(statOe), .power(power), .mode(mode));
`default_nettype wire

//--- testbench/cmf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmf_host_model (
  // status pin
  input wire logic statOe,
  output logic statIn
);
  // board pull-up: a released pin reads high
  assign statIn = statOe ? 1'b0 : 1'b1;
endmodule // cmf_host_model
`default_nettype wire

//--- testbench/charger_mode_fault_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cmf_cfg.svh"
module charger_mode_fault_control_tb_top
  import cmf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic otgActive = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  cmf_sense_t sense = '0;
  logic pready, pslverr, statIn, statOut, statOe, rerr;
  logic [31:0] prdata, rd;
  cmf_power_t power;
  cmf_mode_t mode;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  cmf_charger_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sense(sense), .otgActive(otgActive), .statIn(statIn),
    .statOut(statOut), .statOe(statOe), .power(power), .mode(mode));
  cmf_host_model host_u (.statOe(statOe), .statIn(statIn));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // look at pready where it is settled, then take the sampling edge
    @(negedge clk_sys);
    while (pready !== 1'b1 && n < 16)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n == 16)
      chk(32'h0000_0000, 32'h0000_0001);
  endtask
  // fault pulse must hold the pin low for exactly 128 us
  task automatic pulse();
    int n;
    n = 0;
    repeat (7000) @(posedge clk_sys) if (statIn === 1'b0) n++;
    chk(n, `CMF_PULSE_CYC);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(mode, CMF_HIZ);
    chk(statIn, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(rerr, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `CMF_OFF_STATUS, 32'h0000_0000);
    chk(rd[7:0], 8'h02);
    sense.busAboveLockout <= 1'b1;
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0002);
    apb(1'b0, `CMF_OFF_STATUS, 32'h0000_0000);
    chk(rd[5], 1'b1);
    $display("reset test done");
  endtask
  task automatic t_charge();
    tick(2);
    chk(mode, CMF_CHG);
    chk(statIn, 1'b0);
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0000);
    tick(3);
    chk(statIn, 1'b1);
    chk(power.chargeOn, 1'b1);
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0004);
    tick(3);
    chk(power.chargeOn, 1'b0);
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0000);
    tick(3);
    sense.poorSource <= 1'b1;
    pulse();
    chk(mode, CMF_CFG);
    sense.busAboveLockout <= 1'b0;
    tick(3);
    chk(mode, CMF_HIZ);
    sense.busAboveLockout <= 1'b1;
    sense.poorSource <= 1'b0;
    tick(6500);
    $display("charge test done");
  endtask
  task automatic t_boost();
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0010);
    tick(3);
    chk(mode, CMF_BST);
    chk(statIn, 1'b1);
    sense.busOver <= 1'b1;
    pulse();
    chk(mode, CMF_CFG);
    apb(1'b0, `CMF_OFF_CTRL, 32'h0000_0000);
    chk(rd[4], 1'b0);
    apb(1'b0, `CMF_OFF_FAULT, 32'h0000_0000);
    chk(rd[1], 1'b1);
    sense.busOver <= 1'b0;
    apb(1'b1, `CMF_OFF_FAULT, 32'h0000_0002);
    apb(1'b0, `CMF_OFF_FAULT, 32'h0000_0000);
    chk(rd[1], 1'b0);
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0010);
    tick(3);
    chk(mode, CMF_BST);
    sense.battUnder <= 1'b1;
    pulse();
    apb(1'b0, `CMF_OFF_FAULT, 32'h0000_0000);
    chk(rd[3], 1'b1);
    sense.battUnder <= 1'b0;
    apb(1'b1, `CMF_OFF_FAULT, 32'h0000_0008);
    $display("boost test done");
  endtask
  task automatic t_otg();
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0000);
    otgActive <= 1'b1;
    tick(3);
    chk(mode, CMF_BST);
    sense.inductorLow <= 1'b1;
    tick(3);
    chk(power.pwmOn, 1'b0);
    sense.midRailLow <= 1'b1;
    tick(3);
    chk(power.pwmOn, 1'b1);
    sense.inductorLow <= 1'b0;
    sense.midRailLow <= 1'b0;
    otgActive <= 1'b0;
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0020);
    tick(3);
    chk(mode, CMF_HIZ);
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0021);
    apb(1'b0, `CMF_OFF_CTRL, 32'h0000_0000);
    chk(rd[5:0], 6'h20);
    // parameter reset issued only while idle in high impedance
    apb(1'b1, `CMF_OFF_CTRL, 32'h0000_0028);
    apb(1'b0, `CMF_OFF_CTRL, 32'h0000_0000);
    chk(rd[5:0], 6'h00);
    $display("otg and hiz test done");
  endtask
  initial
  begin
    tick(6);
    nrst <= 1'b1;
    t_reset();
    t_charge();
    t_boost();
    t_otg();
    tally_and_finish();
  end
endmodule // charger_mode_fault_control_tb_top
`default_nettype wire
